// *** pkg/spe_consts.svh ***
`ifndef SPE_CONSTS_SVH
`define SPE_CONSTS_SVH

// ************************************
// Opcodes, taken MSB first
// ************************************
`define SPE_OP_WR_EN_VAL 8'h06
`define SPE_OP_WR_DIS_VAL 8'h04
`define SPE_OP_ST_RD_VAL 8'h05
`define SPE_OP_ST_WR_VAL 8'h01
`define SPE_OP_READ_VAL 8'h03
`define SPE_OP_WRITE_VAL 8'h02

// ************************************
// Status byte bit positions
// ************************************
`define SPE_SB_GUARD_EN 7
`define SPE_SB_ID_SEL 6
`define SPE_SB_LOCK 4
`define SPE_SB_BP_HI 3
`define SPE_SB_BP_LO 2

// ************************************
// Frame and timing figures
// ************************************
`define SPE_LAST_HDR_BIT 5'h1F
`define SPE_TWC_NS 5000000
`define SPE_CLK_NS 5
`define SPE_WC_W 20

`endif

// *** pkg/spe_pkg.sv ***
package spe_pkg;

	// Frame states, one-hot
	typedef enum logic [7:0] {
		SPE_IDLE = 8'h01,
		SPE_OPC = 8'h02,
		SPE_ADDR = 8'h04,
		SPE_RDATA = 8'h08,
		SPE_WDATA = 8'h10,
		SPE_SRD = 8'h20,
		SPE_SWR = 8'h40,
		SPE_IGN = 8'h80
	} spe_state_e;

endpackage : spe_pkg

// *** rtl/spe_eeprom_ctrl.sv ***
`timescale 1ns/1ps
`include "spe_consts.svh"

// Overview of operation
// - Busy flag high through whole programming cycle
// - Enable-writes sets latch, disable-writes clears it
// - Status byte bit order fixed, bit5 zero
// - Block guard bits select protected range
// - Writes into protected range are dropped
// - Pin guard active blocks status writes
// - Array needs latch; status needs latch, no guard
// - Page select steers to id page, auto-clears
// - Id page lock makes page read-only until reset
// - Setting select and lock together changes neither
// - Status write touches only bits 2,3,4,6,7
// - Latch cleared at reset; host enables first
// - Write: opcode, 24-bit address, data, 17 used
// - Program starts at CS rise; busy ignores most
// - Page load wraps inside 256-byte page
// - Finished write cycle clears the latch
// - Id page writes use byte bits, guard A16:A15
// - Pin fall after status-write opcode abandons the frame
// - Array read streams, address wraps to zero
// - Id page read increments byte address
// - Decode enable, disable writes and status read
// - Decode status write, array read, array write
// - Sample on SCK rise, shift out on fall
// - Status read answered even while busy
module spe_eeprom_ctrl #(
	parameter int unsigned WC_CYCLES = `SPE_TWC_NS / `SPE_CLK_NS
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_sck_i,
	input wire logic spi_si_i,
	input wire logic guard_pin_n_i,
	input wire logic [7:0] mem_rdata_i,
	output logic spi_so_o,
	output logic spi_so_oe_o,
	output logic [16:0] mem_addr_o,
	output logic mem_id_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_we_o
);
	// ************************************
	// Pin synchronisers and edge finding
	// ************************************
	logic [3:0] s1_reg, s2_reg, s3_reg;

	// Only the second and third stages are read, first stays private
	always_ff @(posedge clk_i) begin
		s1_reg <= {spi_cs_n_i, spi_sck_i, spi_si_i, guard_pin_n_i};
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	wire cs_low = ~s2_reg[3];
	wire cs_fall = ~s2_reg[3] & s3_reg[3];
	wire cs_rise = s2_reg[3] & ~s3_reg[3];
	wire sck_rise = cs_low & s2_reg[2] & ~s3_reg[2];
	wire sck_fall = cs_low & ~s2_reg[2] & s3_reg[2];
	wire si = s2_reg[1];
	wire pin_fall = ~s2_reg[0] & s3_reg[0];

	// ************************************
	// State
	// ************************************
	spe_pkg::spe_state_e state_reg, opc_next;
	logic [4:0] bit_cnt_reg;
	logic [2:0] out_cnt_reg;
	logic [7:0] in_sh_reg, op_reg, out_sh_reg, sw_data_reg, wptr_reg;
	logic [16:0] addr_reg;
	logic pin_guard_enable_reg, id_page_select_reg, id_page_lock_reg;
	logic block_guard_high_reg, block_guard_low_reg, write_latch_reg, busy_reg;
	logic sw_full_reg, got_byte_reg, wp_fell_reg, prog_reg;
	logic [8:0] pidx_reg;
	logic [`SPE_WC_W-1:0] wc_cnt_reg;
	logic [7:0] buf_reg [256];
	logic [255:0] bvalid_reg;
	logic so_reg, so_oe_reg;
	logic [16:0] mem_addr_reg;
	logic mem_id_reg, mem_we_reg;
	logic [7:0] mem_wdata_reg;

	// ************************************
	// Decode
	// ************************************
	wire [7:0] in_next = {in_sh_reg[6:0], si};
	wire byte_done = sck_rise & (bit_cnt_reg[2:0] == 3'h7);
	wire [16:0] addr_next = {addr_reg[15:0], si};
	wire addr_done = sck_rise & (state_reg == spe_pkg::SPE_ADDR) &
		(bit_cnt_reg == `SPE_LAST_HDR_BIT);
	wire [7:0] status_byte = {pin_guard_enable_reg, id_page_select_reg, 1'b0, id_page_lock_reg,
		block_guard_high_reg, block_guard_low_reg, write_latch_reg, busy_reg};
	wire [1:0] bp = {block_guard_high_reg, block_guard_low_reg};
	// Range check on A16:A15 also covers id page writes
	wire prot_hit = (bp == 2'h3) | ((bp == 2'h2) & addr_reg[16]) |
		((bp == 2'h1) & addr_reg[16] & addr_reg[15]);
	wire hw_prot = ~s2_reg[0] & pin_guard_enable_reg;
	wire wr_go = cs_rise & (state_reg == spe_pkg::SPE_WDATA) & got_byte_reg &
		write_latch_reg & ~prot_hit & ~(id_page_select_reg & id_page_lock_reg);
	wire sw_go = cs_rise & (state_reg == spe_pkg::SPE_SWR) & sw_full_reg &
		write_latch_reg & ~hw_prot & ~wp_fell_reg;
	wire both_set = sw_data_reg[`SPE_SB_ID_SEL] & sw_data_reg[`SPE_SB_LOCK];
	wire buf_we = byte_done & (state_reg == spe_pkg::SPE_WDATA);
	wire rd_load = sck_fall & (out_cnt_reg == 3'h0);
	wire [16:0] rd_inc = mem_id_reg ? {mem_addr_reg[16:8], mem_addr_reg[7:0] + 8'h01} :
		mem_addr_reg + 17'h00001;
	wire wc_done = busy_reg & ~prog_reg & (wc_cnt_reg == '0);

	// Opcode table; while busy only the status read gets through
	always_comb begin
		unique case (in_next)
			`SPE_OP_ST_RD_VAL: opc_next = spe_pkg::SPE_SRD;
			`SPE_OP_ST_WR_VAL: opc_next = busy_reg ? spe_pkg::SPE_IGN : spe_pkg::SPE_SWR;
			`SPE_OP_READ_VAL: opc_next = busy_reg ? spe_pkg::SPE_IGN : spe_pkg::SPE_ADDR;
			`SPE_OP_WRITE_VAL: opc_next = busy_reg ? spe_pkg::SPE_IGN : spe_pkg::SPE_ADDR;
			default: opc_next = spe_pkg::SPE_IGN;
		endcase
	end

	// ************************************
	// Frame sequencer
	// ************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !cs_low) begin
			state_reg <= spe_pkg::SPE_IDLE;
			bit_cnt_reg <= 5'h00;
			in_sh_reg <= 8'h00;
		end else if (cs_fall) begin
			state_reg <= spe_pkg::SPE_OPC;
			bit_cnt_reg <= 5'h00;
		end else if (sck_rise) begin
			in_sh_reg <= in_next;
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			if (state_reg == spe_pkg::SPE_OPC && byte_done)
				state_reg <= opc_next;
			else if (addr_done)
				state_reg <= (op_reg == `SPE_OP_READ_VAL) ? spe_pkg::SPE_RDATA : spe_pkg::SPE_WDATA;
		end
	end

	// Accepted opcode, address and captured status data
	always_ff @(posedge clk_i) begin
		if (!nrst_i || cs_fall) begin
			op_reg <= 8'h00;
			sw_data_reg <= 8'h00;
			sw_full_reg <= 1'b0;
			wp_fell_reg <= 1'b0;
			got_byte_reg <= 1'b0;
		end else begin
			if (state_reg == spe_pkg::SPE_OPC && byte_done && !(busy_reg && in_next != `SPE_OP_ST_RD_VAL))
				op_reg <= in_next;
			if (byte_done && state_reg == spe_pkg::SPE_SWR && !sw_full_reg) begin
				sw_data_reg <= in_next;
				sw_full_reg <= 1'b1;
			end
			if (cs_low && pin_fall && pin_guard_enable_reg && state_reg == spe_pkg::SPE_SWR)
				wp_fell_reg <= 1'b1;
			if (buf_we)
				got_byte_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			addr_reg <= 17'h00000;
		else if (sck_rise && state_reg == spe_pkg::SPE_ADDR)
			addr_reg <= addr_next;
	end

	// ************************************
	// Page buffer, write pointer wraps in page
	// ************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i)
			wptr_reg <= 8'h00;
		else if (addr_done)
			wptr_reg <= addr_next[7:0];
		else if (buf_we)
			wptr_reg <= wptr_reg + 8'h01;
	end

	always_ff @(posedge clk_i) begin
		if (buf_we)
			buf_reg[wptr_reg] <= in_next;
	end

	// Valid bits kept while busy, so a status poll cannot wipe the page
	for (genvar g = 0; g < 256; g++) begin : g_valid
		always_ff @(posedge clk_i) begin
			if (!nrst_i || (cs_fall && !busy_reg))
				bvalid_reg[g] <= 1'b0;
			else if (buf_we && wptr_reg == 8'(g))
				bvalid_reg[g] <= 1'b1;
		end
	end

	// ************************************
	// Status byte and write cycle
	// ************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			write_latch_reg <= 1'b0;
			pin_guard_enable_reg <= 1'b0;
			block_guard_high_reg <= 1'b0;
			block_guard_low_reg <= 1'b0;
			id_page_select_reg <= 1'b0;
			id_page_lock_reg <= 1'b0;
		end else begin
			if (wc_done)
				write_latch_reg <= 1'b0;
			else if (cs_rise && op_reg == `SPE_OP_WR_EN_VAL)
				write_latch_reg <= 1'b1;
			else if (cs_rise && op_reg == `SPE_OP_WR_DIS_VAL)
				write_latch_reg <= 1'b0;
			if (sw_go) begin
				pin_guard_enable_reg <= sw_data_reg[`SPE_SB_GUARD_EN];
				block_guard_high_reg <= sw_data_reg[`SPE_SB_BP_HI];
				block_guard_low_reg <= sw_data_reg[`SPE_SB_BP_LO];
				if (!both_set) begin
					id_page_select_reg <= sw_data_reg[`SPE_SB_ID_SEL];
					id_page_lock_reg <= id_page_lock_reg | sw_data_reg[`SPE_SB_LOCK];
				end
			end else if (cs_rise && (state_reg == spe_pkg::SPE_RDATA || state_reg == spe_pkg::SPE_WDATA))
				id_page_select_reg <= 1'b0;
		end
	end

	// Programming walks the buffer, then the cycle timer runs out
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			busy_reg <= 1'b0;
			prog_reg <= 1'b0;
			pidx_reg <= 9'h000;
			wc_cnt_reg <= '0;
		end else if (wr_go || sw_go) begin
			busy_reg <= 1'b1;
			prog_reg <= wr_go;
			pidx_reg <= 9'h000;
			wc_cnt_reg <= `SPE_WC_W'(WC_CYCLES);
		end else if (busy_reg) begin
			if (wc_cnt_reg != '0)
				wc_cnt_reg <= wc_cnt_reg - `SPE_WC_W'(1);
			if (prog_reg)
				pidx_reg <= pidx_reg + 9'h001;
			if (pidx_reg == 9'h0FF)
				prog_reg <= 1'b0;
			if (wc_done)
				busy_reg <= 1'b0;
		end
	end

	// ************************************
	// Memory port
	// ************************************
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mem_addr_reg <= 17'h00000;
			mem_id_reg <= 1'b0;
			mem_wdata_reg <= 8'h00;
			mem_we_reg <= 1'b0;
		end else begin
			mem_we_reg <= prog_reg & bvalid_reg[pidx_reg[7:0]];
			if (prog_reg) begin
				mem_addr_reg <= {addr_reg[16:8], pidx_reg[7:0]};
				mem_wdata_reg <= buf_reg[pidx_reg[7:0]];
			end else if (addr_done) begin
				mem_addr_reg <= addr_next;
				mem_id_reg <= id_page_select_reg;
			end else if (rd_load && state_reg == spe_pkg::SPE_RDATA)
				mem_addr_reg <= rd_inc;
		end
	end

	// ************************************
	// Serial output, changes on SCK fall
	// ************************************
	wire [7:0] load_byte = (state_reg == spe_pkg::SPE_SRD) ? status_byte : mem_rdata_i;
	wire out_phase = (state_reg == spe_pkg::SPE_SRD) || (state_reg == spe_pkg::SPE_RDATA);
	always_ff @(posedge clk_i) begin
		if (!nrst_i || !cs_low) begin
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
			out_sh_reg <= 8'h00;
			out_cnt_reg <= 3'h0;
		end else if (sck_fall && out_phase) begin
			so_oe_reg <= 1'b1;
			out_cnt_reg <= out_cnt_reg + 3'h1;
			so_reg <= rd_load ? load_byte[7] : out_sh_reg[7];
			out_sh_reg <= rd_load ? {load_byte[6:0], 1'b0} : {out_sh_reg[6:0], 1'b0};
		end
	end

	assign spi_so_o = so_reg;
	assign spi_so_oe_o = so_oe_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_id_o = mem_id_reg;
	assign mem_wdata_o = mem_wdata_reg;
	assign mem_we_o = mem_we_reg;
	// ************************************
	// Checks
	// ************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	busy_start_a: assert property ($rose(busy_reg) |-> $past(cs_rise))
		else $error("busy rose without chip select rise");
	busy_end_a: assert property ($fell(busy_reg) |-> !write_latch_reg && $past(wc_cnt_reg) == '0)
		else $error("busy fell early or latch kept");
	latch_set_a: assert property (cs_rise && op_reg == `SPE_OP_WR_EN_VAL && !busy_reg |=> write_latch_reg)
		else $error("enable writes did not set latch");
	status_out_a: assert property (sck_fall && state_reg == spe_pkg::SPE_SRD && out_cnt_reg == 3'h0
		|=> spi_so_o == $past(status_byte[7]) && spi_so_oe_o)
		else $error("status byte not shifted out");
	prot_write_a: assert property (mem_we_o |-> !(bp == 2'h3 ||
		(bp == 2'h2 && mem_addr_o[16]) || (bp == 2'h1 && mem_addr_o[16:15] == 2'h3)))
		else $error("write landed in protected range");
	guard_block_a: assert property (cs_rise && state_reg == spe_pkg::SPE_SWR && hw_prot
		|=> $stable(bp) && $stable(pin_guard_enable_reg))
		else $error("status write passed pin guard");
	both_set_a: assert property (sw_go && both_set
		|=> $stable(id_page_select_reg) && $stable(id_page_lock_reg))
		else $error("select and lock changed together");
	lock_keep_a: assert property (id_page_lock_reg |=> id_page_lock_reg)
		else $error("page lock cleared");
	page_wrap_a: assert property (buf_we && wptr_reg == 8'hFF |=> wptr_reg == 8'h00)
		else $error("page pointer did not wrap");
	read_inc_a: assert property (rd_load && state_reg == spe_pkg::SPE_RDATA && !mem_id_reg
		|=> mem_addr_o == $past(mem_addr_reg) + 17'h00001)
		else $error("read address did not advance");
	prog_cov_c: cover property (wr_go ##1 busy_reg);
	sr_busy_c: cover property (busy_reg && state_reg == spe_pkg::SPE_SRD && sck_fall);
	sw_cov_c: cover property (sw_go);
	rd_wrap_c: cover property (rd_load && mem_addr_reg == 17'h1FFFF && !mem_id_reg);
endmodule : spe_eeprom_ctrl

// *** test/spe_host_model.sv ***
`timescale 1ns/1ps

// ************************************
// Host side of the serial link
// ************************************
module spe_host_model (
	input wire logic clk_i,
	input wire logic so_i,
	input wire logic cpol_i,
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o
);
	localparam int HALF = 8; // 80 ns serial period at 5 ns
	logic [15:0] rx_reg;

	// Idle: select high, clock parked low
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		rx_reg = 16'h0000;
	end

	// One whole frame of n bytes; the last two bytes from SO are kept
	task automatic xfer(input logic [47:0] tx, input int n);
		int i;
		sck_o <= cpol_i; // Park clock for mode 0 or 3 before select falls
		repeat (HALF) @(posedge clk_i);
		cs_n_o <= 1'b0;
		repeat (HALF) @(posedge clk_i);
		for (i = 8 * n - 1; i >= 0; i--) begin
			sck_o <= 1'b0;
			si_o <= tx[i];
			repeat (HALF) @(posedge clk_i);
			sck_o <= 1'b1;
			rx_reg <= {rx_reg[14:0], so_i};
			repeat (HALF) @(posedge clk_i);
		end
		sck_o <= cpol_i;
		repeat (HALF) @(posedge clk_i);
		cs_n_o <= 1'b1;
		si_o <= ~si_o; // Released line must not keep its old value
		repeat (HALF) @(posedge clk_i);
	endtask : xfer
endmodule : spe_host_model

// *** test/spe_eeprom_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "spe_consts.svh"

module spe_eeprom_ctrl_tb;
	localparam int WC = 300; // Shortened write cycle
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic guard_n = 1'b1;
	logic cs_n, sck, si, so, so_oe, mem_id, mem_we;
	logic [16:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	logic [7:0] arr [0:131071];
	logic [7:0] idp [0:255];
	int failures = 0;
	int compares = 0;
	int we_cnt = 0;
	int oe_cnt = 0;
	logic cpol = 1'b0;
	int n;

	always #2.5 clk_i = ~clk_i;

	// ************************************
	// Array and id page beside the block
	// ************************************
	assign mem_rdata = mem_id ? idp[mem_addr[7:0]] : arr[mem_addr];
	always @(posedge clk_i) begin
		if (so_oe === 1'b1)
			oe_cnt++;
		if (mem_we === 1'b1) begin
			we_cnt++;
			if (mem_id)
				idp[mem_addr[7:0]] <= mem_wdata;
			else
				arr[mem_addr] <= mem_wdata;
		end
	end

	spe_eeprom_ctrl #(.WC_CYCLES(WC)) spe_eeprom_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_si_i(si), .guard_pin_n_i(guard_n),
		.mem_rdata_i(mem_rdata), .spi_so_o(so), .spi_so_oe_o(so_oe), .mem_addr_o(mem_addr),
		.mem_id_o(mem_id), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we));

	spe_host_model spe_host_model_inst (.clk_i(clk_i), .so_i(so), .cpol_i(cpol), .cs_n_o(cs_n),
		.sck_o(sck), .si_o(si));

	// ************************************
	// Helpers
	// ************************************
	task automatic conclude();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cmd(input logic [7:0] op);
		spe_host_model_inst.xfer(48'(op), 1);
	endtask : cmd

	task automatic stat(input logic [7:0] exp);
		spe_host_model_inst.xfer(48'({`SPE_OP_ST_RD_VAL, 8'h00}), 2);
		chk("status", {8'h00, exp}, {8'h00, spe_host_model_inst.rx_reg[7:0]});
	endtask : stat

	// Fixed wait: busy lasts WC clocks after the select rise
	task automatic waitwc();
		repeat (WC + 40) @(posedge clk_i);
	endtask : waitwc

	task automatic sr_write(input logic [7:0] v);
		cmd(`SPE_OP_WR_EN_VAL);
		spe_host_model_inst.xfer(48'({`SPE_OP_ST_WR_VAL, v}), 2);
		waitwc();
	endtask : sr_write

	task automatic mem_write(input logic [23:0] a, input logic [7:0] d);
		cmd(`SPE_OP_WR_EN_VAL);
		spe_host_model_inst.xfer(48'({`SPE_OP_WRITE_VAL, a, d}), 5);
		waitwc();
	endtask : mem_write

	task automatic mem_read(input logic [23:0] a, input logic [15:0] exp);
		spe_host_model_inst.xfer({`SPE_OP_READ_VAL, a, 16'h0000}, 6);
		chk("read", exp, spe_host_model_inst.rx_reg);
	endtask : mem_read

	// ************************************
	// Scenarios
	// ************************************
	task automatic t_start();
		n = we_cnt;
		stat(8'h00);
		spe_host_model_inst.xfer(48'({`SPE_OP_WRITE_VAL, 24'h000010, 8'h99}), 5);
		stat(8'h00);
		chk("we count", 16'(n), 16'(we_cnt));
	endtask : t_start

	task automatic t_latch();
		cpol <= 1'b1; // Mode 3: clock parked high between frames
		@(posedge clk_i);
		cmd(`SPE_OP_WR_EN_VAL);
		stat(8'h02);
		cpol <= 1'b0;
		@(posedge clk_i);
		cmd(`SPE_OP_WR_DIS_VAL);
		stat(8'h00);
		n = oe_cnt;
		cmd(8'hFF);
		chk("oe unknown", 16'(n), 16'(oe_cnt));
		stat(8'h00);
		chk("oe status", 16'h0001, {15'h0000, oe_cnt != n});
	endtask : t_latch

	task automatic t_wrap();
		cmd(`SPE_OP_WR_EN_VAL);
		spe_host_model_inst.xfer({`SPE_OP_WRITE_VAL, 24'hFE01FF, 16'hA55A}, 6);
		stat(8'h03);
		waitwc();
		stat(8'h00);
		chk("byte 1FF", 16'h00A5, {8'h00, arr[17'h001FF]});
		chk("byte 100", 16'h005A, {8'h00, arr[17'h00100]});
		mem_read(24'h01FFFF, 16'hC33C);
	endtask : t_wrap

	task automatic t_protect();
		sr_write(8'hFF);
		stat(8'h8C);
		@(posedge clk_i) guard_n <= 1'b0;
		sr_write(8'h00);
		stat(8'h8E);
		@(posedge clk_i) guard_n <= 1'b1;
		sr_write(8'h84);
		stat(8'h84);
		n = we_cnt;
		mem_write(24'h018000, 8'h11);
		chk("we count", 16'(n), 16'(we_cnt));
		mem_write(24'h017FFF, 8'h22);
		chk("byte 17FFF", 16'h0022, {8'h00, arr[17'h17FFF]});
	endtask : t_protect

	// Pin dips inside the status data byte, high again at select rise,
	// so only the abandon logic can refuse this write
	task automatic t_pin_fall();
		cmd(`SPE_OP_WR_EN_VAL);
		fork
			spe_host_model_inst.xfer(48'({`SPE_OP_ST_WR_VAL, 8'h80}), 2);
			begin
				repeat (180) @(posedge clk_i);
				guard_n <= 1'b0;
				repeat (40) @(posedge clk_i);
				guard_n <= 1'b1;
			end
		join
		waitwc();
		stat(8'h86);
		sr_write(8'h00);
		stat(8'h00);
	endtask : t_pin_fall

	task automatic t_idpage();
		sr_write(8'h40);
		stat(8'h40);
		mem_write(24'hFE7EF0, 8'h77);
		chk("id F0", 16'h0077, {8'h00, idp[8'hF0]});
		stat(8'h00);
		sr_write(8'h40);
		mem_read(24'h0000F0, 16'h7788);
		sr_write(8'h10);
		stat(8'h10);
		sr_write(8'h40);
		n = we_cnt;
		mem_write(24'h0000F0, 8'h99);
		chk("we count", 16'(n), 16'(we_cnt));
		chk("id F0", 16'h0077, {8'h00, idp[8'hF0]});
	endtask : t_idpage

	// ************************************
	// Main sequence and watchdog
	// ************************************
	initial begin
		arr[17'h1FFFF] = 8'hC3;
		arr[17'h00000] = 8'h3C;
		arr[17'h18000] = 8'h00;
		idp[8'hF1] = 8'h88;
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_start();
		t_latch();
		t_wrap();
		t_protect();
		t_pin_fall();
		t_idpage();
		conclude();
	end

	// Whole run is about 0.1 ms of traffic
	initial begin
		#250us;
		failures++;
		conclude();
	end
endmodule : spe_eeprom_ctrl_tb
